//--- dac_event_interrupt_unit.sv
`timescale 1ns/1ps
module dac_event_interrupt_unit #(
    parameter int FIFO_PTR_W = dac_event_interrupt_pkg::FIFO_PTR_W
) (
    input  wire logic                                          sys_clk,
    input  wire logic                                          reset_n,
    input  wire dac_event_interrupt_pkg::general_events_t      general_event_in,
    input  wire logic [FIFO_PTR_W-1:0]                         fifo_wr_ptr,
    input  wire logic [FIFO_PTR_W-1:0]                         fifo_rd_ptr,
    input  wire dac_event_interrupt_pkg::reg_req_t             reg_req,
    output logic [dac_event_interrupt_pkg::DATA_W-1:0]         reg_rdata,
    output logic                                               reg_rvalid,
    output logic                                               interrupt_out_a,
    output logic                                               interrupt_out_b
);

    localparam int GW = dac_event_interrupt_pkg::GEN_EVENT_W;
    localparam int FW = dac_event_interrupt_pkg::FIFO_EVENT_W;
    localparam int EW = dac_event_interrupt_pkg::EVENT_W;
    localparam int DW = dac_event_interrupt_pkg::DATA_W;

    dac_event_interrupt_pkg::general_events_t general_flags_r;
    dac_event_interrupt_pkg::fifo_events_t    fifo_flags;
    logic [GW-1:0] general_enable_r;
    logic [FW-1:0] fifo_enable_r;
    logic [GW-1:0] general_route_r;
    logic [FW-1:0] fifo_route_r;
    logic [EW-1:0] all_flags;
    logic [EW-1:0] all_enable;
    logic [EW-1:0] all_route;
    logic [EW-1:0] hit_a;
    logic [EW-1:0] hit_b;
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;
    logic          rvalid_r;
    logic          irq_a_r;
    logic          irq_b_r;

    fifo_level_monitor #(
        .PTR_W      (FIFO_PTR_W)
    ) u_fifo_monitor (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .wr_ptr     (fifo_wr_ptr),
        .rd_ptr     (fifo_rd_ptr),
        .fifo_flags (fifo_flags)
    );

    // General flags track their source conditions; no host write path
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            general_flags_r <= dac_event_interrupt_pkg::GEN_RESET; // see [R12]
        end else begin
            general_flags_r.sync_lost            <= general_event_in.sync_lost;            // see [R2]
            general_flags_r.sync_locked          <= general_event_in.sync_locked;          // see [R3]
            general_flags_r.sync_done            <= general_event_in.sync_done;            // see [R4]
            general_flags_r.pll_lost             <= general_event_in.pll_lost;             // see [R5]
            general_flags_r.pll_locked           <= general_event_in.pll_locked;           // see [R6]
            general_flags_r.power_excess         <= general_event_in.power_excess;         // see [R7]
            general_flags_r.output_silenced_flag <= general_event_in.output_silenced_flag; // see [R8]
        end
    end

    // Enable registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            general_enable_r <= dac_event_interrupt_pkg::GEN_RESET;
            fifo_enable_r    <= dac_event_interrupt_pkg::FIFO_RESET;
        end else if (reg_req.wr_en) begin
            if (reg_req.addr == dac_event_interrupt_pkg::OFS_GENERAL_EVENT_ENABLE) begin
                general_enable_r <= reg_req.wdata[GW-1:0]; // see [R16]
            end
            if (reg_req.addr == dac_event_interrupt_pkg::OFS_FIFO_EVENT_ENABLE) begin
                fifo_enable_r <= reg_req.wdata[FW-1:0]; // see [R1]
            end
        end
    end

    // Routing registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            general_route_r <= dac_event_interrupt_pkg::GEN_RESET;
            fifo_route_r    <= dac_event_interrupt_pkg::FIFO_RESET;
        end else if (reg_req.wr_en) begin
            if (reg_req.addr == dac_event_interrupt_pkg::OFS_GENERAL_EVENT_ROUTING) begin
                general_route_r <= reg_req.wdata[GW-1:0]; // see [R14]
            end
            if (reg_req.addr == dac_event_interrupt_pkg::OFS_FIFO_EVENT_ROUTING) begin
                fifo_route_r <= reg_req.wdata[FW-1:0]; // see [R15]
            end
        end
    end

    assign all_flags  = {fifo_flags, general_flags_r};
    assign all_enable = {fifo_enable_r, general_enable_r};
    assign all_route  = {fifo_route_r, general_route_r};

    generate
        for (genvar i = 0; i < EW; i++) begin : g_event
            assign hit_a[i] = all_flags[i] && all_enable[i] && !all_route[i]; // see [R13]
            assign hit_b[i] = all_flags[i] && all_enable[i] && all_route[i];  // see [R14]
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_a_r <= 1'h0;
            irq_b_r <= 1'h0;
        end else begin
            irq_a_r <= |hit_a; // see [R17]
            irq_b_r <= |hit_b; // see [R17]
        end
    end

    // Readback; unmapped offsets and unused upper bits read zero
    always_comb begin
        rdata_nxt = dac_event_interrupt_pkg::RDATA_RESET;
        case (reg_req.addr)
            dac_event_interrupt_pkg::OFS_GENERAL_EVENT_ENABLE:  rdata_nxt = {{(DW-GW){1'h0}}, general_enable_r};
            dac_event_interrupt_pkg::OFS_FIFO_EVENT_ENABLE:     rdata_nxt = {{(DW-FW){1'h0}}, fifo_enable_r};
            dac_event_interrupt_pkg::OFS_GENERAL_EVENT_FLAGS:   rdata_nxt = {{(DW-GW){1'h0}}, general_flags_r}; // see [R18]
            dac_event_interrupt_pkg::OFS_FIFO_EVENT_FLAGS:      rdata_nxt = {{(DW-FW){1'h0}}, fifo_flags};      // see [R18]
            dac_event_interrupt_pkg::OFS_GENERAL_EVENT_ROUTING: rdata_nxt = {{(DW-GW){1'h0}}, general_route_r};
            dac_event_interrupt_pkg::OFS_FIFO_EVENT_ROUTING:    rdata_nxt = {{(DW-FW){1'h0}}, fifo_route_r};
            default:                                            rdata_nxt = dac_event_interrupt_pkg::RDATA_RESET;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r  <= dac_event_interrupt_pkg::RDATA_RESET;
            rvalid_r <= 1'h0;
        end else begin
            rvalid_r <= reg_req.rd_en;
            if (reg_req.rd_en) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata       = rdata_r;
    assign reg_rvalid      = rvalid_r;
    assign interrupt_out_a = irq_a_r;
    assign interrupt_out_b = irq_b_r;

endmodule // dac_event_interrupt_unit

//--- dac_event_interrupt_pkg.sv
// Notes on behaviour
// [R1] FIFO underflow, overflow, warning enables at bits 2..0 of register 0x04, reset zero.
// [R2] Sync-lost flag, bit 6 of general flags, set when sync alignment is lost.
// [R3] Sync-locked flag, bit 5 of general flags, set when sync achieves lock.
// [R4] Sync-done flag, bit 4 of general flags, set when a sync operation finishes.
// [R5] PLL-lost flag, bit 3 of general flags, set when the PLL loses lock.
// [R6] PLL-locked flag, bit 2 of general flags, set when the PLL attains lock.
// [R7] Power-excess flag, bit 1, set when input power exceeds the programmed threshold.
// [R8] Output-silenced flag, bit 0, set while the output is forced to midscale.
// [R9] FIFO underflow flag, bit 2 of FIFO flags, set when read pointer reaches write pointer.
// [R10] FIFO overflow flag, bit 1 of FIFO flags, set when write pointer reaches read pointer.
// [R11] FIFO warning flag, bit 0, set when fill level is at most 1 or at least 6.
// [R12] Both flag registers are read-only, reset to zero; host writes leave them untouched.
// [R13] An event whose routing bit is zero is driven onto interrupt_out_a.
// [R14] Routing bit one selects interrupt_out_b; general routing bits occupy bits 6..0 of 0x07.
// [R15] FIFO routing bits at bits 2..0 of register 0x08, all reset to zero.
// [R16] General event enables at bits 6..0 of register 0x03, all reset to zero.
// [R17] Each pin is high while any event routed to it is both flagged and enabled.
// [R18] Host reads both flag registers to find the source; flags follow their conditions.
package dac_event_interrupt_pkg;

    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 8;
    localparam int GEN_EVENT_W  = 7;
    localparam int FIFO_EVENT_W = 3;
    localparam int EVENT_W      = GEN_EVENT_W + FIFO_EVENT_W;
    localparam int FIFO_PTR_W   = 4;

    localparam logic [ADDR_W-1:0] OFS_GENERAL_EVENT_ENABLE  = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_FIFO_EVENT_ENABLE     = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_GENERAL_EVENT_FLAGS   = 8'h05;
    localparam logic [ADDR_W-1:0] OFS_FIFO_EVENT_FLAGS      = 8'h06;
    localparam logic [ADDR_W-1:0] OFS_GENERAL_EVENT_ROUTING = 8'h07;
    localparam logic [ADDR_W-1:0] OFS_FIFO_EVENT_ROUTING    = 8'h08;

    localparam logic [GEN_EVENT_W-1:0]  GEN_RESET  = 7'h00;
    localparam logic [FIFO_EVENT_W-1:0] FIFO_RESET = 3'h0;
    localparam logic [DATA_W-1:0]       RDATA_RESET = 8'h00;

    localparam int FIFO_WARN_LOW  = 1;
    localparam int FIFO_WARN_HIGH = 6;

    // Field order gives bit 6 down to bit 0
    typedef struct packed {
        logic sync_lost;
        logic sync_locked;
        logic sync_done;
        logic pll_lost;
        logic pll_locked;
        logic power_excess;
        logic output_silenced_flag;
    } general_events_t;

    // Field order gives bit 2 down to bit 0
    typedef struct packed {
        logic fifo_underflow;
        logic fifo_overflow;
        logic fifo_warning;
    } fifo_events_t;

    typedef struct packed {
        logic              wr_en;
        logic              rd_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        MON_CLEAR     = 2'h0,
        MON_UNDERFLOW = 2'h1,
        MON_OVERFLOW  = 2'h2
    } fifo_mon_state_t;

endpackage

//--- fifo_level_monitor.sv
`timescale 1ns/1ps
module fifo_level_monitor #(
    parameter int PTR_W = dac_event_interrupt_pkg::FIFO_PTR_W
) (
    input  wire logic                                 sys_clk,
    input  wire logic                                 reset_n,
    input  wire logic [PTR_W-1:0]                     wr_ptr,
    input  wire logic [PTR_W-1:0]                     rd_ptr,
    output dac_event_interrupt_pkg::fifo_events_t     fifo_flags
);

    dac_event_interrupt_pkg::fifo_mon_state_t state_r;
    dac_event_interrupt_pkg::fifo_mon_state_t state_nxt;
    logic [PTR_W-1:0] wr_prev_r;
    logic [PTR_W-1:0] rd_prev_r;
    logic             primed_r;
    logic             warning_r;
    logic [PTR_W-1:0] level;
    logic             slots_equal;
    logic             rd_moved;
    logic             wr_moved;

    assign level       = wr_ptr - rd_ptr;
    assign slots_equal = (wr_ptr[PTR_W-2:0] == rd_ptr[PTR_W-2:0]);
    assign rd_moved    = primed_r && (rd_ptr != rd_prev_r);
    assign wr_moved    = primed_r && (wr_ptr != wr_prev_r);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_prev_r <= '0;
            rd_prev_r <= '0;
            primed_r  <= 1'h0;
        end else begin
            wr_prev_r <= wr_ptr;
            rd_prev_r <= rd_ptr;
            primed_r  <= 1'h1;
        end
    end

    // Held while pointers sit on the same slot after a catch
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dac_event_interrupt_pkg::MON_CLEAR: begin
                if (slots_equal && rd_moved) begin
                    state_nxt = dac_event_interrupt_pkg::MON_UNDERFLOW; // see [R9]
                end else if (slots_equal && wr_moved) begin
                    state_nxt = dac_event_interrupt_pkg::MON_OVERFLOW; // see [R10]
                end
            end
            dac_event_interrupt_pkg::MON_UNDERFLOW,
            dac_event_interrupt_pkg::MON_OVERFLOW: begin
                if (!slots_equal) begin
                    state_nxt = dac_event_interrupt_pkg::MON_CLEAR; // see [R18]
                end
            end
            default: state_nxt = dac_event_interrupt_pkg::MON_CLEAR;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= dac_event_interrupt_pkg::MON_CLEAR;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            warning_r <= 1'h0;
        end else begin
            warning_r <= (level <= PTR_W'(dac_event_interrupt_pkg::FIFO_WARN_LOW)) ||
                         (level >= PTR_W'(dac_event_interrupt_pkg::FIFO_WARN_HIGH)); // see [R11]
        end
    end

    assign fifo_flags.fifo_underflow = (state_r == dac_event_interrupt_pkg::MON_UNDERFLOW);
    assign fifo_flags.fifo_overflow  = (state_r == dac_event_interrupt_pkg::MON_OVERFLOW);
    assign fifo_flags.fifo_warning   = warning_r;

endmodule // fifo_level_monitor

//--- dac_event_interrupt_unit_asserts.sv
`timescale 1ns/1ps
module dac_event_interrupt_unit_asserts #(
    parameter int FIFO_PTR_W = 4
) (
    input wire logic                                  sys_clk,
    input wire logic                                  reset_n,
    input wire dac_event_interrupt_pkg::general_events_t general_event_in,
    input wire logic [FIFO_PTR_W-1:0]                 fifo_wr_ptr,
    input wire logic [FIFO_PTR_W-1:0]                 fifo_rd_ptr,
    input wire dac_event_interrupt_pkg::reg_req_t     reg_req,
    input wire logic [7:0]                            reg_rdata,
    input wire logic                                  reg_rvalid,
    input wire logic                                  interrupt_out_a,
    input wire logic                                  interrupt_out_b
);
    logic [6:0]            en_g_r, rt_g_r, flg_r;
    logic [2:0]            en_f_r, rt_f_r;
    logic [FIFO_PTR_W-1:0] lvl;
    logic                  warn_w, pin_a_w, pin_b_w;
    assign lvl     = fifo_wr_ptr - fifo_rd_ptr;
    assign warn_w  = (lvl <= 1) || (lvl >= 6);
    assign pin_a_w = |(flg_r & en_g_r & ~rt_g_r);
    assign pin_b_w = |(flg_r & en_g_r & rt_g_r);
    // Shadow of the host-visible registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {en_g_r, rt_g_r, flg_r, en_f_r, rt_f_r} <= '0;
        end else begin
            flg_r <= general_event_in;
            if (reg_req.wr_en && reg_req.addr == 8'h03) en_g_r <= reg_req.wdata[6:0];
            if (reg_req.wr_en && reg_req.addr == 8'h04) en_f_r <= reg_req.wdata[2:0];
            if (reg_req.wr_en && reg_req.addr == 8'h07) rt_g_r <= reg_req.wdata[6:0];
            if (reg_req.wr_en && reg_req.addr == 8'h08) rt_f_r <= reg_req.wdata[2:0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd(logic [7:0] a);
        reg_req.rd_en && reg_req.addr == a;
    endsequence
    property p_rvalid; reg_req.rd_en |=> reg_rvalid; endproperty
    property p_no_rvalid; !reg_req.rd_en |=> !reg_rvalid; endproperty
    property p_en_g; s_rd(8'h03) |=> reg_rdata == {1'b0, $past(en_g_r)}; endproperty
    property p_en_f; s_rd(8'h04) |=> reg_rdata == {5'h00, $past(en_f_r)}; endproperty
    property p_flags; s_rd(8'h05) |=> reg_rdata == {1'b0, $past(flg_r)}; endproperty
    property p_rt_g; s_rd(8'h07) |=> reg_rdata == {1'b0, $past(rt_g_r)}; endproperty
    property p_rt_f; s_rd(8'h08) |=> reg_rdata == {5'h00, $past(rt_f_r)}; endproperty
    property p_warn; s_rd(8'h06) |=> reg_rdata[0] == $past(warn_w, 2); endproperty
    property p_pin_a; $past(en_f_r) == 3'h0 |-> interrupt_out_a == $past(pin_a_w); endproperty
    property p_pin_b; $past(en_f_r) == 3'h0 |-> interrupt_out_b == $past(pin_b_w); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read without valid pulse");
    a_no_rvalid: assert property (p_no_rvalid) else $error("stray valid pulse");
    a_en_g: assert property (p_en_g) else $error("general enable readback wrong");
    a_en_f: assert property (p_en_f) else $error("fifo enable readback wrong");
    a_flags: assert property (p_flags) else $error("general flags wrong");
    a_rt_g: assert property (p_rt_g) else $error("general routing readback wrong");
    a_rt_f: assert property (p_rt_f) else $error("fifo routing readback wrong");
    a_warn: assert property (p_warn) else $error("fifo warning wrong");
    a_pin_a: assert property (p_pin_a) else $error("pin a wrong");
    a_pin_b: assert property (p_pin_b) else $error("pin b wrong");
endmodule // dac_event_interrupt_unit_asserts
bind dac_event_interrupt_unit dac_event_interrupt_unit_asserts #(.FIFO_PTR_W(FIFO_PTR_W)) u_asserts (.sys_clk,
    .reset_n, .general_event_in, .fifo_wr_ptr, .fifo_rd_ptr, .reg_req, .reg_rdata, .reg_rvalid,
    .interrupt_out_a, .interrupt_out_b);

//--- host_irq_model.sv
`timescale 1ns/1ps
module host_irq_model (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       irq_a,
    input  wire logic       irq_b,
    output logic      [7:0] rise_a,
    output logic      [7:0] rise_b
);
    logic prev_a_r, prev_b_r;
    // Each rise is a point where the host would fetch both flag bytes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {prev_a_r, prev_b_r, rise_a, rise_b} <= '0;
        end else begin
            prev_a_r <= irq_a;
            prev_b_r <= irq_b;
            rise_a   <= rise_a + 8'(irq_a && !prev_a_r);
            rise_b   <= rise_b + 8'(irq_b && !prev_b_r);
        end
    end
endmodule // host_irq_model

//--- dac_event_interrupt_unit_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module dac_event_interrupt_unit_bench;
    localparam int LIMIT_CYC = 5000;
    logic                              sys_clk = 1'b0;
    logic                              reset_n = 1'b0;
    logic [6:0]                        evb = 7'h00;
    logic [3:0]                        wp = 4'h4, rp = 4'h0;
    dac_event_interrupt_pkg::reg_req_t req = '0;
    logic [7:0]                        rdata, rise_a, rise_b, ea = 8'h00, eb = 8'h00, seed = 8'h41;
    logic                              rvalid, irq_a, irq_b;
    logic [7:0]                        ad [6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
    logic [7:0]                        mk [6] = '{8'h7F, 8'h07, 8'h00, 8'h00, 8'h7F, 8'h07};
    logic [3:0]                        wt [7] = '{4'h4, 4'h4, 4'hA, 4'h9, 4'hC, 4'hC, 4'hC};
    logic [3:0]                        rt [7] = '{4'h3, 4'h4, 4'h4, 4'h4, 4'h4, 4'h6, 4'hA};
    logic [1:0]                        ft [7] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0};
    int                                fails = 0, cmp_count = 0;
    always #2.5 sys_clk = ~sys_clk;
    dac_event_interrupt_unit u_dac_event_interrupt_unit (.sys_clk(sys_clk), .reset_n(reset_n),
        .general_event_in(evb), .fifo_wr_ptr(wp), .fifo_rd_ptr(rp), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .interrupt_out_a(irq_a), .interrupt_out_b(irq_b));
    host_irq_model u_host_irq_model (.sys_clk(sys_clk), .reset_n(reset_n), .irq_a(irq_a), .irq_b(irq_b),
        .rise_a(rise_a), .rise_b(rise_b));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic warn_of(input logic [3:0] w, input logic [3:0] r);
        return (4'(w - r) <= 4'h1) || (4'(w - r) >= 4'h6);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
        @(posedge sys_clk);
        req.wr_en <= 1'b0;
    endtask
    task automatic chk_rd(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        req.rd_en <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK(n, e, rdata)
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic reset_and_check();
        @(posedge sys_clk);
        reset_n <= 1'b0;
        {evb, wp, rp} <= {7'h00, 4'h4, 4'h0};
        repeat (4) @(posedge sys_clk);
        `CHK("pins_in_reset", 2'b00, {irq_a, irq_b})
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++) chk_rd("reset_value", ad[i], 8'h00);
        chk_rd("unmapped", 8'h09, 8'h00);
        $display("test reset done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #(LIMIT_CYC * 5);
        fails++;
        give_verdict();
    end
    initial begin
        reset_and_check();
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            wr(ad[i % 6], seed);
            chk_rd("readback", ad[i % 6], seed & mk[i % 6]);
        end
        $display("test registers done");
        // Mask FIFO events so the pin checks see only general events
        wr(8'h04, 8'h00);
        wr(8'h03, 8'h7F);
        seed = lfsr(seed);
        wr(8'h07, seed);
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            evb <= 7'(1 << i);
            if (!seed[i] && (i == 0 || seed[i - 1])) ea++;
            if (seed[i] && (i == 0 || !seed[i - 1])) eb++;
            settle();
            `CHK("pin_a", ~seed[i], irq_a)
            `CHK("pin_b", seed[i], irq_b)
            chk_rd("general_flags", 8'h05, 8'(1 << i));
        end
        `CHK("host_rises", {ea, eb}, {rise_a, rise_b})
        wr(8'h03, 8'h00);
        settle();
        `CHK("pins_disabled", 2'b00, {irq_a, irq_b})
        $display("test events done");
        wr(8'h04, 8'h07);
        wr(8'h08, 8'h07);
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            {wp, rp} <= {wt[i], rt[i]};
            settle();
            `CHK("fifo_pin_b", |{ft[i], warn_of(wt[i], rt[i])}, irq_b)
            chk_rd("fifo_flags", 8'h06, {5'h00, ft[i], warn_of(wt[i], rt[i])});
        end
        // FIFO events routed back to pin a; read pointer catches write slot
        wr(8'h08, 8'h00);
        @(posedge sys_clk);
        rp <= 4'h4;
        settle();
        `CHK("fifo_pin_a", 2'b10, {irq_a, irq_b})
        chk_rd("fifo_catch", 8'h06, 8'h05);
        $display("test fifo done");
        reset_and_check();
        give_verdict();
    end
endmodule // dac_event_interrupt_unit_bench
